/* hw/sgp_gate_unit.sv */
`timescale 1ns/1ps
module sgp_gate_unit
    import sgp_pkg::*;
(
    input  wire logic        CLOCK_I,
    input  wire logic        RST_I,
    input  wire logic        PROT_ENTER_I,
    input  wire logic        LONG_ENTER_I,
    input  wire logic        COMPAT_I,
    input  wire logic [63:0] GDT_BASE_I,
    input  wire logic        GDT_LOAD_I,
    input  wire logic [63:0] LDT_BASE_I,
    input  wire logic        LDT_LOAD_I,
    input  sgp_req_t         REQ_I,
    input  wire logic [15:0] REQ_SEL_RAW_I,
    input  wire logic        DESC_VALID_I,
    input  sgp_desc_t        DESC_I,
    input  sgp_desc_t        TGT_DESC_I,
    input  wire logic [15:0] TSS_SS_I,
    output logic             DESC_RD_O,
    output logic [63:0]      DESC_ADDR_O,
    output sgp_rsp_t         RSP_O,
    output logic             PROT_FAULT_O,
    output logic [1:0]       CPL_O,
    output logic [1:0]       MODE_O
);
    typedef enum {S_IDLE, S_FETCH} sgp_state_t;

    sgp_mode_t   mode_reg, mode_next;
    logic [1:0]  cpl_reg, cpl_next;
    logic [63:0] gdt_reg, gdt_next;
    logic [63:0] ldt_reg, ldt_next;
    sgp_state_t  st_reg, st_next;
    sgp_req_t    req_reg, req_next;
    sgp_rsp_t    rsp_reg, rsp_next;
    logic        rd_reg, rd_next;
    logic [63:0] addr_reg, addr_next;
    logic        flt_reg, flt_next;

    sgp_sel_t    sel_dec;
    logic [63:0] dec_addr;
    logic        wide;
    logic        long_m;
    logic        seg_ok;
    logic        gate_ok;
    logic        tgt_ok;

    assign long_m = (mode_reg == SGP_LONG64) || (mode_reg == SGP_COMPAT);
    assign wide   = (mode_reg == SGP_LONG64);

    sgp_sel_decode u_dec (
        .raw_i       (REQ_SEL_RAW_I),
        .gdt_base_i  (gdt_reg),
        .ldt_base_i  (ldt_reg),
        .wide_i      (wide),
        .sel_o       (sel_dec),
        .desc_addr_o (dec_addr)
    );

    sgp_priv_check u_seg (
        .cpl_i     (cpl_reg),
        .rpl_i     (req_reg.sel.rpl),
        .dpl_i     (DESC_I.dpl),
        .is_code_i (1'b0),
        .conf_i    (1'b0),
        .ok_o      (seg_ok)
    );

    sgp_priv_check u_gate (
        .cpl_i     (cpl_reg),
        .rpl_i     (req_reg.sel.rpl),
        .dpl_i     (DESC_I.dpl),
        .is_code_i (1'b0),
        .conf_i    (1'b0),
        .ok_o      (gate_ok)
    );

    sgp_priv_check u_tgt (
        .cpl_i     (cpl_reg),
        .rpl_i     (2'h0),
        .dpl_i     (TGT_DESC_I.dpl),
        .is_code_i (1'b1),
        .conf_i    (TGT_DESC_I.code_conf),
        .ok_o      (tgt_ok)
    );

    // mode and table base registers
    always_comb begin
        mode_next = mode_reg;
        gdt_next  = gdt_reg;
        ldt_next  = ldt_reg;
        if (PROT_ENTER_I && mode_reg == SGP_REAL) begin
            mode_next = SGP_PROT;
        end else if (LONG_ENTER_I && mode_reg == SGP_PROT) begin
            mode_next = SGP_LONG64;
        end else if (long_m) begin
            mode_next = COMPAT_I ? SGP_COMPAT : SGP_LONG64;
        end
        if (GDT_LOAD_I) begin
            gdt_next = long_m ? GDT_BASE_I
                : {32'h0, GDT_BASE_I[31:0]};
        end
        if (LDT_LOAD_I) begin
            ldt_next = long_m ? LDT_BASE_I
                : {32'h0, LDT_BASE_I[31:0]};
        end
    end

    // translation and gate sequencer
    always_comb begin
        st_next   = st_reg;
        req_next  = req_reg;
        rsp_next  = rsp_reg;
        rd_next   = 1'b0;
        addr_next = addr_reg;
        flt_next  = 1'b0;
        cpl_next  = cpl_reg;
        rsp_next.done  = 1'b0;
        rsp_next.fault = 1'b0;
        case (st_reg)
            S_IDLE: begin
                if (REQ_I.valid) begin
                    if (mode_reg == SGP_REAL) begin
                        // real mode, no descriptor and no check
                        rsp_next.done   = 1'b1;
                        rsp_next.linear = {44'h0,
                            REQ_SEL_RAW_I, 4'h0} + REQ_I.offset;
                        rsp_next.err_code     = SGP_ERR_ZERO;
                        rsp_next.stack_switch = 1'b0;
                    end else begin
                        req_next     = REQ_I;
                        req_next.sel = sel_dec;
                        addr_next    = dec_addr;
                        rd_next      = 1'b1;
                        st_next      = S_FETCH;
                    end
                end
            end
            S_FETCH: begin
                if (DESC_VALID_I) begin
                    st_next = S_IDLE;
                    rsp_next.done = 1'b1;
                    rsp_next.stack_switch = 1'b0;
                    rsp_next.err_code = SGP_ERR_ZERO;
                    if (!DESC_I.present) begin
                        rsp_next.fault    = 1'b1;
                        rsp_next.err_code = {req_reg.sel.index,
                            req_reg.sel.local_sel, 2'h0};
                        flt_next = 1'b1;
                    end else if (!req_reg.is_call) begin
                        if (seg_ok) begin
                            rsp_next.linear = DESC_I.base
                                + req_reg.offset;
                        end else begin
                            rsp_next.fault    = 1'b1;
                            rsp_next.err_code = SGP_ERR_ZERO;
                            flt_next = 1'b1;
                        end
                    end else if (DESC_I.system
                            && DESC_I.dtype == SGP_TYPE_TASKGATE
                            && long_m) begin
                        rsp_next.fault = 1'b1;
                        flt_next = 1'b1;
                    end else if (DESC_I.system
                            && DESC_I.dtype == SGP_TYPE_CALLGATE) begin
                        if (gate_ok && tgt_ok) begin
                            rsp_next.new_cs = DESC_I.gate_sel;
                            rsp_next.linear = TGT_DESC_I.base
                                + DESC_I.gate_off;
                            rsp_next.new_cpl = TGT_DESC_I.code_conf
                                ? cpl_reg : TGT_DESC_I.dpl;
                            cpl_next = rsp_next.new_cpl;
                            if (!TGT_DESC_I.code_conf
                                    && TGT_DESC_I.dpl < cpl_reg) begin
                                rsp_next.stack_switch = 1'b1;
                                rsp_next.new_ss = long_m ? SGP_NULL_SEL
                                    : TSS_SS_I;
                            end
                        end else begin
                            rsp_next.fault    = 1'b1;
                            rsp_next.err_code = SGP_ERR_ZERO;
                            flt_next = 1'b1;
                        end
                    end else begin
                        rsp_next.fault    = 1'b1;
                        rsp_next.err_code = SGP_ERR_ZERO;
                        flt_next = 1'b1;
                    end
                end else begin
                    rd_next = 1'b1;
                end
            end
            default: begin
                st_next = S_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLOCK_I) begin
        if (RST_I) begin
            mode_reg <= SGP_REAL;
            cpl_reg  <= SGP_RESET_CPL;
            gdt_reg  <= 64'h0;
            ldt_reg  <= 64'h0;
            st_reg   <= S_IDLE;
            req_reg  <= '0;
            rsp_reg  <= '0;
            rd_reg   <= 1'b0;
            addr_reg <= 64'h0;
            flt_reg  <= 1'b0;
        end else begin
            mode_reg <= mode_next;
            cpl_reg  <= cpl_next;
            gdt_reg  <= gdt_next;
            ldt_reg  <= ldt_next;
            st_reg   <= st_next;
            req_reg  <= req_next;
            rsp_reg  <= rsp_next;
            rd_reg   <= rd_next;
            addr_reg <= addr_next;
            flt_reg  <= flt_next;
        end
    end

    assign DESC_RD_O    = rd_reg;
    assign DESC_ADDR_O  = addr_reg;
    assign RSP_O        = rsp_reg;
    assign PROT_FAULT_O = flt_reg;
    assign CPL_O        = cpl_reg;
    assign MODE_O       = mode_reg;
endmodule

/* common/sgp_pkg.sv */
package sgp_pkg;
    localparam int SGP_ADDR_W     = 64;
    localparam int SGP_SEL_IDX_LO = 3;
    localparam int SGP_SEL_TI_BIT = 2;
    localparam logic [63:0] SGP_LEGACY_DESC_BYTES = 64'h8;
    localparam logic [63:0] SGP_LONG_DESC_BYTES   = 64'h10;
    localparam logic [3:0]  SGP_TYPE_LDT      = 4'h2;
    localparam logic [3:0]  SGP_TYPE_TASKGATE = 4'h5;
    localparam logic [3:0]  SGP_TYPE_TSS      = 4'h9;
    localparam logic [3:0]  SGP_TYPE_CALLGATE = 4'hc;
    localparam logic [15:0] SGP_ERR_ZERO      = 16'h0000;
    localparam logic [15:0] SGP_NULL_SEL      = 16'h0000;
    localparam logic [1:0]  SGP_RESET_CPL     = 2'h0;

    typedef enum logic [1:0] {SGP_REAL, SGP_PROT, SGP_LONG64, SGP_COMPAT}
        sgp_mode_t;

    typedef struct packed {
        logic [12:0] index;
        logic        local_sel;
        logic [1:0]  rpl;
    } sgp_sel_t;

    // fields of a fetched descriptor, flattened
    typedef struct packed {
        logic [63:0] base;
        logic [15:0] gate_sel;
        logic [63:0] gate_off;
        logic [1:0]  dpl;
        logic        present;
        logic        system;
        logic [3:0]  dtype;
        logic        code_conf;
    } sgp_desc_t;

    typedef struct packed {
        logic        valid;
        logic        is_call;
        sgp_sel_t    sel;
        logic [63:0] offset;
    } sgp_req_t;

    typedef struct packed {
        logic        done;
        logic        fault;
        logic [15:0] err_code;
        logic [63:0] linear;
        logic [15:0] new_cs;
        logic [15:0] new_ss;
        logic        stack_switch;
        logic [1:0]  new_cpl;
    } sgp_rsp_t;

    function automatic logic [63:0] sgp_desc_addr(input logic [63:0] tbase,
            input logic [12:0] idx, input logic wide);
        logic [63:0] step;
        step = wide ? SGP_LONG_DESC_BYTES : SGP_LEGACY_DESC_BYTES;
        return tbase + 64'(idx) * step;
    endfunction
endpackage

/* hw/sgp_sel_decode.sv */
`timescale 1ns/1ps
module sgp_sel_decode
    import sgp_pkg::*;
(
    input  wire logic [15:0] raw_i,
    input  wire logic [63:0] gdt_base_i,
    input  wire logic [63:0] ldt_base_i,
    input  wire logic        wide_i,
    output sgp_sel_t         sel_o,
    output logic [63:0]      desc_addr_o
);
    always_comb begin
        sel_o.index     = raw_i[15:SGP_SEL_IDX_LO];
        sel_o.local_sel = raw_i[SGP_SEL_TI_BIT];
        sel_o.rpl       = raw_i[1:0];
        desc_addr_o = sgp_desc_addr(raw_i[SGP_SEL_TI_BIT] ? ldt_base_i
            : gdt_base_i, raw_i[15:SGP_SEL_IDX_LO], wide_i);
    end
endmodule

/* hw/sgp_priv_check.sv */
`timescale 1ns/1ps
module sgp_priv_check
    import sgp_pkg::*;
(
    input  wire logic [1:0] cpl_i,
    input  wire logic [1:0] rpl_i,
    input  wire logic [1:0] dpl_i,
    input  wire logic       is_code_i,
    input  wire logic       conf_i,
    output logic            ok_o
);
    logic [1:0] eff;
    always_comb begin
        eff = (cpl_i > rpl_i) ? cpl_i : rpl_i;
        // code targets: equal or numerically lower only
        if (is_code_i) begin
            ok_o = conf_i ? (dpl_i <= cpl_i) : (dpl_i <= cpl_i);
        end else begin
            ok_o = (dpl_i >= eff);
        end
    end
endmodule

/* verification/sgp_gate_asserts.sv */
`timescale 1ns/1ps
module sgp_gate_asserts
    import sgp_pkg::*;
(
    input wire logic       CLOCK_I,
    input wire logic       RST_I,
    input wire logic       PROT_ENTER_I,
    input sgp_req_t        REQ_I,
    input wire logic       DESC_VALID_I,
    input wire logic       DESC_RD_O,
    input sgp_rsp_t        RSP_O,
    input wire logic       PROT_FAULT_O,
    input wire logic [1:0] CPL_O,
    input wire logic [1:0] MODE_O
);
    default clocking @(posedge CLOCK_I); endclocking
    default disable iff (RST_I);
    logic idle;
    assign idle = !RSP_O.done && !DESC_RD_O;

    a_reset_real: assert property (
        $past(RST_I) |-> MODE_O == 2'h0 && CPL_O == 2'h0)
        else $error("reset left mode or level set");
    a_real_exit: assert property (
        $past(MODE_O) == 2'h0 && MODE_O != 2'h0 |-> MODE_O == 2'h1)
        else $error("real mode left for other than protected");
    a_prot_exit: assert property (
        $past(MODE_O) == 2'h1 && MODE_O != 2'h1 |-> MODE_O[1])
        else $error("protected mode left for real mode");
    a_prot_enter: assert property (
        MODE_O == 2'h0 && PROT_ENTER_I |=> MODE_O == 2'h1)
        else $error("protected entry not taken");
    a_real_answer: assert property (
        MODE_O == 2'h0 && REQ_I.valid && idle |=> RSP_O.done && !DESC_RD_O)
        else $error("real mode access not answered directly");
    a_prot_fetch: assert property (
        MODE_O != 2'h0 && REQ_I.valid && idle |=> DESC_RD_O && !RSP_O.done)
        else $error("protected access skipped descriptor");
    a_fetch_done: assert property (
        DESC_RD_O && DESC_VALID_I |=> RSP_O.done && !DESC_RD_O)
        else $error("descriptor arrival not answered");
    a_fault_flag: assert property (
        PROT_FAULT_O |-> RSP_O.done && RSP_O.fault)
        else $error("protection fault without faulted answer");
    a_cpl_inward: assert property (
        CPL_O <= $past(CPL_O))
        else $error("privilege level moved outward");
    a_long_null_ss: assert property (
        RSP_O.done && RSP_O.stack_switch && MODE_O[1]
            |-> RSP_O.new_ss == SGP_NULL_SEL)
        else $error("long mode stack selector not null");
endmodule

bind sgp_gate_unit sgp_gate_asserts u_sgp_gate_asserts (
    .CLOCK_I(CLOCK_I), .RST_I(RST_I), .PROT_ENTER_I(PROT_ENTER_I),
    .REQ_I(REQ_I), .DESC_VALID_I(DESC_VALID_I), .DESC_RD_O(DESC_RD_O),
    .RSP_O(RSP_O), .PROT_FAULT_O(PROT_FAULT_O), .CPL_O(CPL_O),
    .MODE_O(MODE_O));

/* verification/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
    import sgp_pkg::*;
    typedef struct {
        logic [15:0] sel;
        logic        call;
        logic [1:0]  dpl;
        logic [3:0]  ty;
        logic        sys;
        logic [1:0]  tdpl;
        logic        pres;
        logic        flt;
        logic [15:0] err;
    } sgp_row_t;
    localparam logic [63:0] DB  = 64'h8000;
    localparam logic [63:0] OFF = 64'h44;
    localparam logic [3:0]  CG  = SGP_TYPE_CALLGATE;
    logic        clk, rst, pe, le, cm, gl, ll, dv, rd, pf, seen_pf;
    logic [63:0] gb, lb, da, addr;
    logic [15:0] raw, ss;
    logic [1:0]  current_privilege_level, mode;
    sgp_req_t    req;
    sgp_desc_t   dsc, tgt, dd;
    sgp_rsp_t    rsp, got;
    sgp_row_t    r;
    int          error_cnt, tests_run, cyc;
    sgp_row_t rows [7] = '{
        '{16'h0010, 1'h0, 2'h0, 4'h2, 1'h0, 2'h0, 1'h1, 1'h0, 16'h0},
        '{16'h000f, 1'h0, 2'h3, 4'h2, 1'h0, 2'h0, 1'h1, 1'h0, 16'h0},
        '{16'h0017, 1'h0, 2'h0, 4'h2, 1'h0, 2'h0, 1'h1, 1'h1, 16'h0},
        '{16'h0020, 1'h0, 2'h0, 4'h2, 1'h0, 2'h0, 1'h0, 1'h1, 16'h0020},
        '{16'h0028, 1'h1, 2'h3, CG, 1'h1, 2'h0, 1'h1, 1'h0, 16'h0},
        '{16'h0028, 1'h1, 2'h3, CG, 1'h1, 2'h2, 1'h1, 1'h1, 16'h0},
        '{16'h0033, 1'h1, 2'h0, CG, 1'h1, 2'h0, 1'h1, 1'h1, 16'h0}};

    sgp_gate_unit u_sgp_gate_unit (
        .CLOCK_I(clk), .RST_I(rst), .PROT_ENTER_I(pe), .LONG_ENTER_I(le),
        .COMPAT_I(cm), .GDT_BASE_I(gb), .GDT_LOAD_I(gl), .LDT_BASE_I(lb),
        .LDT_LOAD_I(ll), .REQ_I(req), .REQ_SEL_RAW_I(raw),
        .DESC_VALID_I(dv), .DESC_I(dsc), .TGT_DESC_I(tgt), .TSS_SS_I(ss),
        .DESC_RD_O(rd), .DESC_ADDR_O(da), .RSP_O(rsp),
        .PROT_FAULT_O(pf), .CPL_O(current_privilege_level), .MODE_O(mode));

    initial begin
        clk = 1'h0;
        forever #20 clk = ~clk;
    end

    task automatic print_verdict;
        $display("checks %0d errors %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: saw %h not %h", $time, seen, exp);
        end
    endtask

    function automatic sgp_desc_t mk(input logic [1:0] dp,
            input logic [3:0] ty, input logic sy, input logic p);
        mk = '0;
        mk.base = DB;
        mk.gate_sel = 16'h0018;
        mk.gate_off = 64'h400;
        mk.dpl = dp;
        mk.present = p;
        mk.system = sy;
        mk.dtype = ty;
    endfunction

    // one access, entered and left at a falling edge
    task automatic xfer(input logic [15:0] s, input logic c,
            input sgp_desc_t d, input sgp_desc_t t);
        int k;
        raw = s;
        req.is_call = c;
        req.valid = 1'h1;
        dsc = d;
        tgt = t;
        @(negedge clk);
        req.valid = 1'h0;
        for (k = 0; k < 4 && rd !== 1'h1 && rsp.done !== 1'h1; k++)
            @(negedge clk);
        addr = da;
        if (rd === 1'h1) begin
            dv = 1'h1;
            @(negedge clk);
            dv = 1'h0;
            dsc = ~d;
            tgt = ~t;
        end
        got = rsp;
        seen_pf = pf;
        chk(got.done, 1'h1);
        @(negedge clk);
    endtask

    task automatic pulse_load(input logic lng, input logic prt);
        le = lng;
        pe = prt;
        @(negedge clk);
        {le, pe, gl, ll} = 4'h3;
        @(negedge clk);
        {gl, ll} = 2'h0;
    endtask

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            error_cnt++;
            print_verdict;
        end
    end

    initial begin
        rst = 1'h1;
        {pe, le, cm, gl, ll, dv} = 6'h0;
        req = '0;
        req.offset = OFF;
        raw = 16'h0;
        dsc = '0;
        tgt = '0;
        gb = 64'h1_0000_2000;
        lb = 64'h5_0000_3000;
        ss = 16'h0040;
        dd = mk(2'h0, 4'h2, 1'h0, 1'h1);
        repeat (12) @(negedge clk);
        rst = 1'h0;
        chk({current_privilege_level, mode}, 4'h0);
        pulse_load(1'h1, 1'h0);
        chk(mode, 2'h0);
        pulse_load(1'h0, 1'h1);
        chk(mode, 2'h1);
        foreach (rows[i]) begin
            r = rows[i];
            xfer(r.sel, r.call, mk(r.dpl, r.ty, r.sys, r.pres),
                 mk(r.tdpl, 4'ha, 1'h0, 1'h1));
            chk(addr, (r.sel[2] ? 64'h3000 : 64'h2000)
                + 64'(r.sel[15:3]) * 64'h8);
            chk(got.fault, r.flt);
            chk(seen_pf, r.flt);
            if (r.flt)
                chk(got.err_code, r.err);
            else if (r.call) begin
                chk(got.new_cs, 16'h0018);
                chk({got.new_cpl, got.stack_switch}, {r.tdpl, 1'h0});
            end else
                chk(got.linear, DB + OFF);
        end
        pulse_load(1'h1, 1'h0);
        chk(mode, 2'h2);
        xfer(16'h0010, 1'h0, dd, dd);
        chk(addr, 64'h1_0000_2020);
        xfer(16'h0028, 1'h1, mk(2'h3, SGP_TYPE_TASKGATE, 1'h1, 1'h1), dd);
        chk({got.fault, got.err_code}, {1'h1, 16'h0});
        cm = 1'h1;
        @(negedge clk);
        chk(mode, 2'h3);
        xfer(16'h0010, 1'h0, dd, dd);
        chk(addr, 64'h1_0000_2010);
        xfer(16'h0028, 1'h1, mk(2'h3, CG, 1'h1, 1'h1), dd);
        chk(got.new_cs, 16'h0018);
        rst = 1'h1;
        repeat (2) @(negedge clk);
        rst = 1'h0;
        chk(mode, 2'h0);
        xfer(16'h1234, 1'h0, dd, dd);
        chk(got.linear, 64'h12340 + OFF);
        print_verdict;
    end
endmodule
